/* src/nvm_fuse_eeprom_ctrl.sv */
// Operation
// - signature read returns byte during load instruction
// - execute, load, store instructions trigger commands
// - fuse read: busy, halt, result in data byte
// - lock write: busy and halt until done
// - lock write clears eeprom and flash buffers
// - lock write accepted from any section
// - lock bits only become more secure
// - eeprom triggers need unlock unless external; mapped load and store need none
// - byte or whole page eeprom writes
// - eeprom read: one byte, no busy
// - address selects location, data byte carries value
// - low bits pick byte, upper bits page
// - eeprom optionally mapped into data space
// - mapped store uses low address bits only
// - mapped store stalls cpu two cycles
// - mapped mode disables register load and read
// - buffer fill fires on data byte access
// - page erase/write ops busy, no halt
// - buffer and full erase busy; nop idle
// - data byte write loads addressed buffer byte
// - array ops touch only tagged bytes
`timescale 1ns/100ps
`include "nvm_regs.svh"
`default_nettype none
module nvm_fuse_eeprom_ctrl #(
  parameter int         BYTE_MSB     = 4,
  parameter int         PAGE_MSB     = 9,
  parameter logic [6:0] SIG_READ_CMD = 7'h01
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  input  wire logic                         ce,
  // command registers
  input  wire logic [6:0]                   cmd,
  input  wire logic [15:0]                  addr,
  input  wire logic                         exec_set,
  input  wire logic                         dbyte_wr,
  input  wire logic [7:0]                   dbyte_wdata,
  input  wire logic                         unlock_open,
  input  wire logic                         ext_prog,
  input  wire logic                         eeprom_mapped,
  // cpu instructions and mapped access
  input  wire logic                         pmload_exec,
  input  wire logic [15:0]                  pmload_addr,
  input  wire logic                         mm_store,
  input  wire logic                         mm_load,
  input  wire logic [15:0]                  mm_addr,
  input  wire logic [7:0]                   mm_wdata,
  // array answers
  input  wire logic [7:0]                   fuse_rdata,
  input  wire logic [7:0]                   sig_rdata,
  input  wire logic [7:0]                   ee_rdata,
  input  wire logic                         array_done,
  // status and data
  output logic                              busy_q,
  output logic                              cpu_halt_q,
  output logic                              cpu_stall_q,
  output logic [7:0]                        dbyte_q,
  output logic [7:0]                        lock_bits_q,
  output logic [7:0]                        pmload_data_q,
  output logic                              pmload_valid_q,
  output logic [7:0]                        mm_rdata_q,
  output logic                              mm_rvalid_q,
  // array side
  output logic                              fuse_rd_q,
  output logic                              sig_rd_q,
  output logic                              ee_rd_q,
  output logic [15:0]                       rd_addr_q,
  output var nvm_pkg::array_req_t           req_q,
  output logic                              flash_buf_clear_q,
  output logic [(1<<(BYTE_MSB+1))*8-1:0]    buf_data_q,
  output logic [(1<<(BYTE_MSB+1))-1:0]      buf_tag_q
);
  localparam int BYTES = 1 << (BYTE_MSB + 1);
  localparam int IDX_W = BYTE_MSB + 1;
  // keeps only the page field of an address
  localparam logic [15:0] PAGE_MASK =
    16'((32'h1 << (PAGE_MSB + 1)) - (32'h1 << (BYTE_MSB + 1)));

  // ----------------------------------------
  // trigger decode
  // ----------------------------------------
  nvm_pkg::state_t     state_q, state_d;  // controller state
  logic                idle;              // free for a new trigger
  logic                prot_ok;           // protected trigger allowed
  logic                go;                // accepted execute strobe
  logic                reg_load;          // data byte fill of the buffer
  logic                map_load;          // mapped store into buffer
  logic                buf_load;          // buffer write this cycle
  logic [IDX_W-1:0]    buf_idx;           // buffer byte index
  logic [7:0]          buf_wdata;         // buffer byte
  logic                buf_clear;         // wipe tags

  assign idle    = (state_q == nvm_pkg::ST_IDLE) && !busy_q;
  // external programming needs no unlock sequence
  assign prot_ok = unlock_open || ext_prog;
  assign go      = exec_set && idle;
  // mapped mode shuts the register path off
  assign reg_load = dbyte_wr && idle && prot_ok && !eeprom_mapped
                    && (cmd == `CMD_LOAD_BUFFER);
  assign map_load = mm_store && idle && eeprom_mapped;
  assign buf_load = reg_load || map_load;
  // only the low address bits pick the buffer byte
  assign buf_idx   = map_load ? mm_addr[BYTE_MSB:0]
                              : addr[BYTE_MSB:0];
  assign buf_wdata = map_load ? mm_wdata : dbyte_wdata;

  // ----------------------------------------
  // controller next state
  // ----------------------------------------
  logic                busy_d, halt_d;
  logic [7:0]          dbyte_d, lock_d, pmload_data_d, mm_rdata_d;
  logic                pmload_valid_d, mm_rvalid_d;
  logic                fuse_rd_d, sig_rd_d, ee_rd_d, flash_clr_d;
  logic [15:0]         rd_addr_d;
  nvm_pkg::array_req_t req_d;

  // command decode for execute triggers; signature and mapped reads are checked after it
  always_comb begin
    state_d     = state_q;
    busy_d      = busy_q;
    halt_d      = cpu_halt_q;
    dbyte_d     = dbyte_wr ? dbyte_wdata : dbyte_q;
    lock_d      = lock_bits_q;
    pmload_data_d  = pmload_data_q;
    mm_rdata_d  = mm_rdata_q;
    pmload_valid_d = 1'b0;
    mm_rvalid_d = 1'b0;
    fuse_rd_d   = 1'b0;
    sig_rd_d    = 1'b0;
    ee_rd_d     = 1'b0;
    flash_clr_d = 1'b0;
    buf_clear   = 1'b0;
    rd_addr_d   = rd_addr_q;
    req_d       = '0;
    case (state_q)
      nvm_pkg::ST_IDLE: begin
        if (go) begin
          case (cmd)
            // fuse read halts the cpu, needs no unlock
            `CMD_READ_FUSES: begin
              state_d   = nvm_pkg::ST_FUSE;
              busy_d    = 1'b1;
              halt_d    = 1'b1;
              fuse_rd_d = 1'b1;
              rd_addr_d = addr;
            end
            // lock write from either flash section
            `CMD_WRITE_LOCK: begin
              if (prot_ok) begin
                lock_d      = lock_bits_q & dbyte_q;
                buf_clear   = 1'b1;
                flash_clr_d = 1'b1;
                state_d     = nvm_pkg::ST_ARRAY;
                busy_d      = 1'b1;
                halt_d      = 1'b1;
                req_d       = '{1'b1, nvm_pkg::OP_LOCK, 16'h0000};
              end
            end
            // page operations carry the page field only
            `CMD_ERASE_PAGE, `CMD_WRITE_PAGE, `CMD_ERASE_WRITE_PAGE: begin
              if (prot_ok) begin
                state_d    = nvm_pkg::ST_ARRAY;
                busy_d     = 1'b1;
                req_d.valid = 1'b1;
                req_d.addr = addr & PAGE_MASK;
                req_d.op   = (cmd == `CMD_ERASE_PAGE) ? nvm_pkg::OP_PAGE_ERASE :
                             (cmd == `CMD_WRITE_PAGE) ? nvm_pkg::OP_PAGE_WRITE :
                                                        nvm_pkg::OP_PAGE_ERASE_WRITE;
              end
            end
            // no address for these two
            `CMD_ERASE_BUFFER, `CMD_ERASE_EEPROM: begin
              if (prot_ok) begin
                state_d     = nvm_pkg::ST_ARRAY;
                busy_d      = 1'b1;
                req_d.valid = 1'b1;
                req_d.op    = (cmd == `CMD_ERASE_BUFFER) ? nvm_pkg::OP_BUF_ERASE
                                                         : nvm_pkg::OP_EE_ERASE;
              end
            end
            // single byte read, no busy and no halt
            `CMD_READ_EEPROM: begin
              if (prot_ok && !eeprom_mapped) begin
                state_d   = nvm_pkg::ST_EE_RD;
                ee_rd_d   = 1'b1;
                rd_addr_d = addr;
              end
            end
            // nop and unknown codes do nothing
            default: begin
              state_d = nvm_pkg::ST_IDLE;
            end
          endcase
        end else if (pmload_exec && cmd == SIG_READ_CMD) begin
          state_d   = nvm_pkg::ST_SIG;
          sig_rd_d  = 1'b1;
          rd_addr_d = pmload_addr;
        end else if (mm_load && eeprom_mapped) begin
          state_d   = nvm_pkg::ST_MM_RD;
          ee_rd_d   = 1'b1;
          rd_addr_d = mm_addr;
        end
      end
      // fuse byte arrives the cycle after the strobe
      nvm_pkg::ST_FUSE: begin
        dbyte_d = fuse_rdata;
        busy_d  = 1'b0;
        halt_d  = 1'b0;
        state_d = nvm_pkg::ST_IDLE;
      end
      // wait for the array, busy ends on its done
      nvm_pkg::ST_ARRAY: begin
        if (array_done) begin
          busy_d  = 1'b0;
          halt_d  = 1'b0;
          state_d = nvm_pkg::ST_IDLE;
        end
      end
      nvm_pkg::ST_EE_RD: begin
        dbyte_d = ee_rdata;
        state_d = nvm_pkg::ST_IDLE;
      end
      nvm_pkg::ST_MM_RD: begin
        mm_rdata_d  = ee_rdata;
        mm_rvalid_d = 1'b1;
        state_d     = nvm_pkg::ST_IDLE;
      end
      nvm_pkg::ST_SIG: begin
        pmload_data_d  = sig_rdata;
        pmload_valid_d = 1'b1;
        state_d     = nvm_pkg::ST_IDLE;
      end
      default: begin
        state_d = nvm_pkg::ST_IDLE;
      end
    endcase
  end

  // controller registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q           <= nvm_pkg::ST_IDLE;
      busy_q            <= 1'b0;
      cpu_halt_q        <= 1'b0;
      dbyte_q           <= `DATA_RESET;
      lock_bits_q       <= `LOCK_RESET;
      pmload_data_q     <= `DATA_RESET;
      pmload_valid_q    <= 1'b0;
      mm_rdata_q        <= `DATA_RESET;
      mm_rvalid_q       <= 1'b0;
      fuse_rd_q         <= 1'b0;
      sig_rd_q          <= 1'b0;
      ee_rd_q           <= 1'b0;
      rd_addr_q         <= '0;
      req_q             <= '0;
      flash_buf_clear_q <= 1'b0;
    end else if (ce) begin
      state_q           <= state_d;
      busy_q            <= busy_d;
      cpu_halt_q        <= halt_d;
      dbyte_q           <= dbyte_d;
      lock_bits_q       <= lock_d;
      pmload_data_q     <= pmload_data_d;
      pmload_valid_q    <= pmload_valid_d;
      mm_rdata_q        <= mm_rdata_d;
      mm_rvalid_q       <= mm_rvalid_d;
      fuse_rd_q         <= fuse_rd_d;
      sig_rd_q          <= sig_rd_d;
      ee_rd_q           <= ee_rd_d;
      rd_addr_q         <= rd_addr_d;
      req_q             <= req_d;
      flash_buf_clear_q <= flash_clr_d;
    end
  end

  // ----------------------------------------
  // mapped store stall
  // ----------------------------------------
  logic [1:0] stall_cnt_q, stall_cnt_d;  // cycles left to stall

  // two stall cycles after each mapped buffer store
  always_comb begin
    stall_cnt_d = stall_cnt_q;
    if (map_load) begin
      stall_cnt_d = `MM_STALL_CYCLES;
    end else if (stall_cnt_q != 2'h0) begin
      stall_cnt_d = stall_cnt_q - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stall_cnt_q <= 2'h0;
      cpu_stall_q <= 1'b0;
    end else if (ce) begin
      stall_cnt_q <= stall_cnt_d;
      cpu_stall_q <= (stall_cnt_d != 2'h0);
    end
  end

  // ----------------------------------------
  // page buffer, tags tell the array what to touch
  // ----------------------------------------
  page_buffer #(
    .BYTES (BYTES),
    .IDX_W (IDX_W)
  ) page_buffer_inst (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .load    (buf_load),
    .idx     (buf_idx),
    .wdata   (buf_wdata),
    .clear   (buf_clear),
    .data_q  (buf_data_q),
    .tag_q   (buf_tag_q)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !ce);

  property p_fuse;
    idle && exec_set && cmd == `CMD_READ_FUSES
      |=> busy_q && cpu_halt_q && fuse_rd_q ##1 !busy_q && dbyte_q == $past(fuse_rdata);
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse read sequence wrong");

  property p_lock;
    idle && exec_set && cmd == `CMD_WRITE_LOCK && prot_ok
      |=> busy_q && cpu_halt_q && req_q.valid && req_q.op == nvm_pkg::OP_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("lock write not started");

  property p_lock_clear;
    lock_bits_q != $past(lock_bits_q) |-> flash_buf_clear_q && buf_tag_q == '0;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("buffers kept on lock write");

  property p_lock_secure;
    (lock_bits_q & ~$past(lock_bits_q)) == 8'h00;
  endproperty
  a_lock_secure: assert property (p_lock_secure) else $error("lock bit relaxed");

  property p_protect;
    idle && exec_set && cmd == `CMD_WRITE_PAGE && !prot_ok |=> !busy_q && !req_q.valid;
  endproperty
  a_protect: assert property (p_protect) else $error("unprotected trigger accepted");

  property p_ee_read;
    idle && exec_set && cmd == `CMD_READ_EEPROM && prot_ok && !eeprom_mapped
      |=> ee_rd_q && !busy_q && !cpu_halt_q ##1 dbyte_q == $past(ee_rdata);
  endproperty
  a_ee_read: assert property (p_ee_read) else $error("eeprom read wrong");

  property p_stall;
    map_load |=> cpu_stall_q ##1 cpu_stall_q ##1 !cpu_stall_q;
  endproperty
  a_stall: assert property (p_stall) else $error("mapped store stall not two cycles");

  property p_map_block;
    eeprom_mapped && dbyte_wr && !mm_store |=> buf_tag_q == $past(buf_tag_q);
  endproperty
  a_map_block: assert property (p_map_block) else $error("register load while mapped");

  property p_fill;
    reg_load |=> buf_tag_q[$past(addr[BYTE_MSB:0])] && !busy_q;
  endproperty
  a_fill: assert property (p_fill) else $error("buffer fill missing");

  property p_page_op;
    idle && exec_set && cmd == `CMD_ERASE_PAGE && prot_ok
      |=> busy_q && !cpu_halt_q && req_q.addr == (($past(addr)) & PAGE_MASK);
  endproperty
  a_page_op: assert property (p_page_op) else $error("page erase start wrong");

  property p_busy_ignore;
    busy_q && exec_set |=> !req_q.valid;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("trigger taken while busy");

  property p_sig;
    idle && !exec_set && pmload_exec && cmd == SIG_READ_CMD
      |=> sig_rd_q ##1 pmload_valid_q && pmload_data_q == $past(sig_rdata);
  endproperty
  a_sig: assert property (p_sig) else $error("signature read wrong");

  c_lock: cover property (req_q.valid && req_q.op == nvm_pkg::OP_LOCK ##[1:20] !busy_q);
  c_fill: cover property (reg_load ##1 reg_load);
  c_stall: cover property (map_load ##3 map_load);
endmodule
`default_nettype wire

/* src/nvm_regs.svh */
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_NOP              7'h00
`define CMD_READ_EEPROM      7'h06
`define CMD_READ_FUSES       7'h07
`define CMD_WRITE_LOCK       7'h08
`define CMD_ERASE_EEPROM     7'h30
`define CMD_ERASE_PAGE       7'h32
`define CMD_LOAD_BUFFER      7'h33
`define CMD_WRITE_PAGE       7'h34
`define CMD_ERASE_WRITE_PAGE 7'h35
`define CMD_ERASE_BUFFER     7'h36
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define LOCK_RESET           8'hff
`define DATA_RESET           8'h00
`define MM_STALL_CYCLES      2'h2
`endif

/* src/nvm_pkg.sv */
package nvm_pkg;
  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FUSE,
    ST_ARRAY,
    ST_EE_RD,
    ST_MM_RD,
    ST_SIG
  } state_t;
  // ----------------------------------------
  // array operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE,
    OP_LOCK,
    OP_BUF_ERASE,
    OP_PAGE_ERASE,
    OP_PAGE_WRITE,
    OP_PAGE_ERASE_WRITE,
    OP_EE_ERASE
  } array_op_t;
  // request to the array, valid for one cycle
  typedef struct packed {
    logic        valid;
    array_op_t   op;
    logic [15:0] addr;
  } array_req_t;
endpackage

/* src/page_buffer.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// eeprom page buffer with load tags
// ----------------------------------------
module page_buffer #(
  parameter int BYTES = 32,
  parameter int IDX_W = 5
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // load and clear
  input  wire logic               load,
  input  wire logic [IDX_W-1:0]   idx,
  input  wire logic [7:0]         wdata,
  input  wire logic               clear,
  // contents
  output logic      [BYTES*8-1:0] data_q,
  output logic      [BYTES-1:0]   tag_q
);
  logic [BYTES*8-1:0] data_d;   // next contents
  logic [BYTES-1:0]   tag_d;    // next tags

  // clear wins over a load in the same cycle
  always_comb begin
    data_d = data_q;
    tag_d  = tag_q;
    if (clear) begin
      tag_d = '0;
    end else if (load) begin
      data_d[idx*8 +: 8] = wdata;
      tag_d[idx]         = 1'b1;
    end
  end

  // only registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= '0;
      tag_q  <= '0;
    end else if (ce) begin
      data_q <= data_d;
      tag_q  <= tag_d;
    end
  end
endmodule
`default_nettype wire

/* tb/nvm_array_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// array side model: read data and op completion
// ----------------------------------------
module nvm_array_model (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // strobes from the controller
  input  wire logic                fuse_rd_q,
  input  wire logic                sig_rd_q,
  input  wire logic                ee_rd_q,
  input  wire logic [15:0]         rd_addr_q,
  input  wire nvm_pkg::array_req_t req_q,
  input  wire logic [3:0]          done_delay,
  // answers
  output logic      [7:0]          fuse_rdata,
  output logic      [7:0]          sig_rdata,
  output logic      [7:0]          ee_rdata,
  output var logic                 array_done
);
  logic [3:0] cnt_q; // cycles left to completion
  // data valid only while its strobe stands; inverted otherwise so a late sample shows
  assign fuse_rdata = fuse_rd_q ? rd_addr_q[7:0] ^ 8'h5a : ~(rd_addr_q[7:0] ^ 8'h5a);
  assign sig_rdata  = sig_rd_q ? rd_addr_q[7:0] ^ 8'ha5 : ~(rd_addr_q[7:0] ^ 8'ha5);
  assign ee_rdata   = ee_rd_q ? rd_addr_q[7:0] ^ 8'h3c : ~(rd_addr_q[7:0] ^ 8'h3c);
  // completion pulse a programmable time after each request; a done_delay of 0 gives none
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q      <= 4'h0;
      array_done <= 1'b0;
    end else begin
      array_done <= 1'b0;
      if (req_q.valid) begin
        cnt_q <= done_delay;
      end else if (cnt_q == 4'h1) begin
        cnt_q      <= 4'h0;
        array_done <= 1'b1;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/nvm_fuse_eeprom_ctrl_tb.sv */
`timescale 1ns/100ps
`include "nvm_regs.svh"
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module nvm_fuse_eeprom_ctrl_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic ref_clk = 0, rstn = 0, ce = 1, exec_set = 0, dbyte_wr = 0, unlock_open = 0;
  logic ext_prog = 0, eeprom_mapped = 0, pmload_exec = 0, mm_store = 0, mm_load = 0;
  logic [6:0] cmd = 7'h00;
  logic [15:0] addr = 16'h0000, pmload_addr = 16'h0000, mm_addr = 16'h0000;
  logic [7:0] dbyte_wdata = 8'h00, mm_wdata = 8'h00;
  logic [3:0] done_delay = 4'h1;
  wire logic [7:0] fuse_rdata, sig_rdata, ee_rdata, dbyte_q, lock_bits_q;
  wire logic [7:0] pmload_data_q, mm_rdata_q;
  wire logic array_done, busy_q, cpu_halt_q, cpu_stall_q, pmload_valid_q, mm_rvalid_q;
  wire logic fuse_rd_q, sig_rd_q, ee_rd_q, flash_buf_clear_q;
  wire logic [15:0] rd_addr_q;
  wire nvm_pkg::array_req_t req_q;
  wire logic [255:0] buf_data_q;
  wire logic [31:0] buf_tag_q;
  int n_mismatch = 0;
  int n_checks = 0;
  always #25 ref_clk = ~ref_clk;
  // ----------------------------------------
  // design and array model
  // ----------------------------------------
  nvm_fuse_eeprom_ctrl nvm_fuse_eeprom_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .cmd(cmd), .addr(addr), .exec_set(exec_set), .dbyte_wr(dbyte_wr),
    .dbyte_wdata(dbyte_wdata), .unlock_open(unlock_open), .ext_prog(ext_prog),
    .eeprom_mapped(eeprom_mapped), .pmload_exec(pmload_exec), .pmload_addr(pmload_addr),
    .mm_store(mm_store), .mm_load(mm_load), .mm_addr(mm_addr), .mm_wdata(mm_wdata),
    .fuse_rdata(fuse_rdata), .sig_rdata(sig_rdata), .ee_rdata(ee_rdata),
    .array_done(array_done), .busy_q(busy_q), .cpu_halt_q(cpu_halt_q),
    .cpu_stall_q(cpu_stall_q), .dbyte_q(dbyte_q), .lock_bits_q(lock_bits_q),
    .pmload_data_q(pmload_data_q), .pmload_valid_q(pmload_valid_q), .mm_rdata_q(mm_rdata_q),
    .mm_rvalid_q(mm_rvalid_q), .fuse_rd_q(fuse_rd_q), .sig_rd_q(sig_rd_q),
    .ee_rd_q(ee_rd_q), .rd_addr_q(rd_addr_q), .req_q(req_q),
    .flash_buf_clear_q(flash_buf_clear_q), .buf_data_q(buf_data_q), .buf_tag_q(buf_tag_q));
  nvm_array_model nvm_array_model_inst (.ref_clk(ref_clk), .rstn(rstn),
    .fuse_rd_q(fuse_rd_q), .sig_rd_q(sig_rd_q), .ee_rd_q(ee_rd_q), .rd_addr_q(rd_addr_q),
    .req_q(req_q), .done_delay(done_delay), .fuse_rdata(fuse_rdata),
    .sig_rdata(sig_rdata), .ee_rdata(ee_rdata), .array_done(array_done));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // inputs always move 1 ns after the edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one command execute pulse; returns one edge later (cycle 1)
  task automatic trig(input logic [6:0] c);
    cmd = c;
    exec_set = 1;
    tick();
    exec_set = 0;
  endtask
  // bounded wait for busy to drop
  task automatic wait_idle();
    for (int i = 0; i < 40 && busy_q !== 1'b0; i++) tick();
    `CHK("busy_end", 1'b0, busy_q)
    tick();
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_fuse();
    addr = 16'h0004;
    trig(`CMD_READ_FUSES);
    `CHK("fuse_busy", 2'b11, {busy_q, cpu_halt_q})
    `CHK("fuse_rd", 17'h10004, {fuse_rd_q, rd_addr_q})
    tick();
    `CHK("fuse_data", 8'h5e, dbyte_q)
    `CHK("fuse_done", 2'b00, {busy_q, cpu_halt_q})
  endtask
  task automatic t_ee_read();
    addr = 16'h0123;
    trig(`CMD_READ_EEPROM);
    `CHK("eerd_noccp", 1'b0, ee_rd_q)
    tick();
    // a busy command without the unlock must be dropped as well
    trig(`CMD_WRITE_PAGE);
    `CHK("wr_locked", 2'b00, {busy_q, req_q.valid})
    tick();
    unlock_open = 1;
    trig(`CMD_READ_EEPROM);
    `CHK("eerd_strobe", 2'b10, {ee_rd_q, busy_q})
    tick();
    `CHK("eerd_data", 8'h1f, dbyte_q)
    `CHK("eerd_nohalt", 2'b00, {busy_q, cpu_halt_q})
  endtask
  task automatic t_fill();
    cmd = `CMD_LOAD_BUFFER;
    addr = 16'h0047;
    dbyte_wdata = 8'hc3;
    dbyte_wr = 1;
    tick();
    dbyte_wr = 0;
    `CHK("fill_tag", 1'b1, buf_tag_q[7])
    `CHK("fill_data", 8'hc3, buf_data_q[63:56])
    `CHK("fill_busy", 2'b00, {busy_q, cpu_halt_q})
    // let an edge pass so the next strobe is a fresh pulse
    tick();
  endtask
  task automatic t_mapped();
    eeprom_mapped = 1;
    cmd = `CMD_LOAD_BUFFER;
    addr = 16'h0049;
    dbyte_wr = 1;
    tick();
    dbyte_wr = 0;
    `CHK("fill_mapped", 1'b0, buf_tag_q[9])
    mm_addr = 16'h105c;
    mm_wdata = 8'h96;
    mm_store = 1;
    tick();
    mm_store = 0;
    `CHK("mm_tag", 9'h196, {buf_tag_q[28], buf_data_q[231:224]})
    `CHK("stall1", 1'b1, cpu_stall_q)
    tick();
    `CHK("stall2", 1'b1, cpu_stall_q)
    tick();
    `CHK("stall3", 1'b0, cpu_stall_q)
    mm_addr = 16'h1011;
    mm_load = 1;
    tick();
    mm_load = 0;
    `CHK("mm_rd", 1'b1, ee_rd_q)
    tick();
    `CHK("mm_data", 9'h12d, {mm_rvalid_q, mm_rdata_q})
    eeprom_mapped = 0;
  endtask
  task automatic t_array(input logic [6:0] c, input nvm_pkg::array_op_t op,
                         input logic [15:0] ea, input logic [3:0] dly);
    done_delay = dly;
    addr = 16'hfe77;
    trig(c);
    `CHK("arr_busy", 2'b10, {busy_q, cpu_halt_q})
    `CHK("arr_req", {1'b1, op, ea}, req_q)
    tick();
    trig(`CMD_READ_FUSES);
    `CHK("arr_ignore", 1'b0, fuse_rd_q)
    wait_idle();
  endtask
  task automatic t_lock(input logic [7:0] v, input logic [7:0] ex);
    cmd = `CMD_WRITE_LOCK;
    dbyte_wdata = v;
    dbyte_wr = 1;
    tick();
    dbyte_wr = 0;
    trig(`CMD_WRITE_LOCK);
    `CHK("lock_busy", 2'b11, {busy_q, cpu_halt_q})
    `CHK("lock_val", ex, lock_bits_q)
    `CHK("lock_clr", 33'h100000000, {flash_buf_clear_q, buf_tag_q})
    tick();
    `CHK("lock_halt", 1'b1, cpu_halt_q)
    wait_idle();
  endtask
  task automatic t_sig();
    cmd = 7'h01;
    pmload_addr = 16'h0033;
    // lone load, nothing interrupts it while the read runs
    pmload_exec = 1;
    tick();
    pmload_exec = 0;
    `CHK("sig_rd", 17'h10033, {sig_rd_q, rd_addr_q})
    tick();
    `CHK("sig_data", 9'h196, {pmload_valid_q, pmload_data_q})
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    tick(16);
    rstn = 1;
    tick();
    `CHK("rst_lock", `LOCK_RESET, lock_bits_q)
    t_fuse();
    t_ee_read();
    t_fill();
    t_mapped();
    trig(`CMD_NOP);
    `CHK("nop", 3'b000, {busy_q, cpu_halt_q, req_q.valid})
    t_array(`CMD_ERASE_PAGE, nvm_pkg::OP_PAGE_ERASE, 16'h0260, 4'h1);
    t_array(`CMD_WRITE_PAGE, nvm_pkg::OP_PAGE_WRITE, 16'h0260, 4'h7);
    t_array(`CMD_ERASE_BUFFER, nvm_pkg::OP_BUF_ERASE, 16'h0000, 4'h3);
    unlock_open = 0;
    ext_prog = 1;
    t_array(`CMD_ERASE_WRITE_PAGE, nvm_pkg::OP_PAGE_ERASE_WRITE, 16'h0260, 4'h2);
    t_array(`CMD_ERASE_EEPROM, nvm_pkg::OP_EE_ERASE, 16'h0000, 4'h5);
    ext_prog = 0;
    unlock_open = 1;
    t_fill();
    t_lock(8'hf0, 8'hf0);
    t_lock(8'hff, 8'hf0);
    t_sig();
    tally_and_finish();
  end
  // whole run is about a hundred cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
